/* File: hw/csoc_pkg.sv */
// package: constants and types for the current sense output control block
// Summary of operation
// - two select bits pick channel 0 current, channel 1 current, or temperature
// - both select bits zero puts the sense output in high impedance
// - track-and-hold keeps pre-turn-off current on the output while switching off
// - sense output disabled while any overcurrent window is active
// - sensing unavailable in fail-safe mode, or in normal mode without logic supply
// - reset low clears all serial registers, sense-select bits included
// - ready line pulled low when value valid, released at channel turn-off
package csoc_pkg;
  localparam int SENSE_WIDTH = 12;
  localparam logic [1:0] SEL_OFF = 2'h0;
  localparam logic [1:0] SEL_CH0 = 2'h1;
  localparam logic [1:0] SEL_CH1 = 2'h2;
  localparam logic [1:0] SEL_TEMP = 2'h3;
  localparam logic [1:0] SEL_RESET = 2'h0;
  localparam int SEL_LOW_POS = 0;
  localparam int SEL_HIGH_POS = 1;
  localparam int CLK_MHZ = 50;
  localparam int RESET_LOW_US = 10;
  localparam int RESET_LOW_CYCLES = RESET_LOW_US * CLK_MHZ;
  localparam logic [3:0] SETTLE_CYCLES = 4'h8;

  typedef enum logic [2:0] {
    SNS_IDLE = 3'b001,
    SNS_SETTLE = 3'b010,
    SNS_VALID = 3'b100
  } csoc_state_type;
endpackage : csoc_pkg

/* File: hw/csoc_sync_if.sv */
// interface: synchronised pin levels passed from the input stage to the core
`timescale 1ns/100ps
interface csoc_sync_if;
  logic [1:0] ch_on;
  logic [1:0] oc_window;
  logic fail_safe;
  logic vdd_ok;
  modport src (output ch_on, output oc_window, output fail_safe, output vdd_ok);
  modport dst (input ch_on, input oc_window, input fail_safe, input vdd_ok);
endinterface : csoc_sync_if

/* File: hw/csoc_sync.sv */
// module: two-stage synchronisers for status levels from outside the clock domain
`timescale 1ns/100ps
module csoc_sync
  import csoc_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [1:0] ch_on_i,
  input wire logic [1:0] oc_window_i,
  input wire logic fail_safe_i,
  input wire logic vdd_ok_i,
  csoc_sync_if.src sync_o
);
  logic [5:0] meta_reg;
  logic [5:0] sync_reg;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_reg <= 6'h00;
      sync_reg <= 6'h00;
    end else begin
      meta_reg <= {vdd_ok_i, fail_safe_i, oc_window_i, ch_on_i};
      sync_reg <= meta_reg;
    end
  end

  assign sync_o.ch_on = sync_reg[1:0];
  assign sync_o.oc_window = sync_reg[3:2];
  assign sync_o.fail_safe = sync_reg[4];
  assign sync_o.vdd_ok = sync_reg[5];
endmodule // csoc_sync

/* File: hw/csoc_top.sv */
// module: sense output source selection, blanking, track-and-hold and ready line
`timescale 1ns/100ps
module csoc_top
  import csoc_pkg::*;
#(
  parameter int WIDTH = SENSE_WIDTH
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic sel_wr_i,
  input wire logic sense_select_low_bit_i,
  input wire logic sense_select_high_bit_i,
  input wire logic track_hold_wr_i,
  input wire logic track_hold_en_i,
  input wire logic [1:0] ch_on_i,
  input wire logic [1:0] oc_window_i,
  input wire logic fail_safe_i,
  input wire logic vdd_ok_i,
  input wire logic [WIDTH-1:0] ch0_current_i,
  input wire logic [WIDTH-1:0] ch1_current_i,
  input wire logic [WIDTH-1:0] temp_i,
  output logic [WIDTH-1:0] sense_output_o,
  output logic sense_output_oe_o,
  output logic sense_ready_o,
  output logic sense_ready_oe_o,
  output logic [1:0] sense_select_o
);
  // ****************************************
  // decoding
  // ****************************************
  // select code to channel mask; temperature and off select no channel
  function automatic logic [1:0] chan_mask_f(input logic [1:0] sel);
    logic [1:0] mask;
    mask = 2'h0;
    if (sel == SEL_CH0) begin
      mask = 2'h1;
    end else if (sel == SEL_CH1) begin
      mask = 2'h2;
    end
    return mask;
  endfunction

  // ****************************************
  // input stage
  // ****************************************
  csoc_sync_if sync_bus ();

  csoc_sync u_sync (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .ch_on_i(ch_on_i),
    .oc_window_i(oc_window_i),
    .fail_safe_i(fail_safe_i),
    .vdd_ok_i(vdd_ok_i),
    .sync_o(sync_bus)
  );

  // ****************************************
  // configuration
  // ****************************************
  logic [1:0] sel_reg;
  logic th_en_reg;
  logic [1:0] sel_next;

  assign sel_next = {sense_select_high_bit_i, sense_select_low_bit_i};

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sel_reg <= SEL_RESET;
      th_en_reg <= 1'b0;
    end else begin
      if (sel_wr_i) begin
        sel_reg <= sel_next;
      end
      if (track_hold_wr_i) begin
        th_en_reg <= track_hold_en_i;
      end
    end
  end

  // ****************************************
  // sample alignment
  // ****************************************
  // two delay stages so samples line up with the synced channel state;
  // buses must be quasi-static, a word caught mid-change is not coherent
  logic [WIDTH-1:0] ch0_d1_reg;
  logic [WIDTH-1:0] ch0_d2_reg;
  logic [WIDTH-1:0] ch1_d1_reg;
  logic [WIDTH-1:0] ch1_d2_reg;
  logic [WIDTH-1:0] temp_d1_reg;
  logic [WIDTH-1:0] temp_d2_reg;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ch0_d1_reg <= '0;
      ch0_d2_reg <= '0;
      ch1_d1_reg <= '0;
      ch1_d2_reg <= '0;
      temp_d1_reg <= '0;
      temp_d2_reg <= '0;
    end else begin
      ch0_d1_reg <= ch0_current_i;
      ch0_d2_reg <= ch0_d1_reg;
      ch1_d1_reg <= ch1_current_i;
      ch1_d2_reg <= ch1_d1_reg;
      temp_d1_reg <= temp_i;
      temp_d2_reg <= temp_d1_reg;
    end
  end

  // ****************************************
  // selection and blanking
  // ****************************************
  logic [1:0] ch_on_d_reg;
  logic [WIDTH-1:0] hold_reg;
  logic hold_act_reg;
  logic [1:0] sel_ch_onehot;
  logic sel_is_ch;
  logic sel_ch_on;
  logic turn_off;
  logic turn_on;
  logic blank;
  logic [WIDTH-1:0] live_val;
  logic [WIDTH-1:0] out_next;
  logic oe_next;
  logic hold_now;
  logic settle_go;

  assign sel_ch_onehot = chan_mask_f(sel_reg);
  assign sel_is_ch = |sel_ch_onehot;
  assign sel_ch_on = |(sel_ch_onehot & sync_bus.ch_on);
  assign turn_off = |(sel_ch_onehot & ch_on_d_reg & ~sync_bus.ch_on);
  assign turn_on = |(sel_ch_onehot & ~ch_on_d_reg & sync_bus.ch_on);
  // no logic supply, fail-safe or any overcurrent window forces the pin off
  assign blank = (|sync_bus.oc_window) || sync_bus.fail_safe || !sync_bus.vdd_ok;
  assign live_val = sel_ch_onehot[0] ? ch0_d2_reg :
                    sel_ch_onehot[1] ? ch1_d2_reg : temp_d2_reg;
  // hold starts in the turn-off cycle itself, so no late live sample slips out
  assign hold_now = hold_act_reg || (turn_off && th_en_reg);
  assign out_next = hold_now ? hold_reg : live_val;
  assign oe_next = (sel_reg != SEL_OFF) && !blank;
  // ready follows the level, so a channel already on when selected still settles
  assign settle_go = sel_ch_on && oe_next && !turn_off && !sel_wr_i;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ch_on_d_reg <= 2'h0;
      hold_reg <= '0;
      hold_act_reg <= 1'b0;
    end else begin
      ch_on_d_reg <= sync_bus.ch_on;
      if (sel_ch_on && !turn_off) begin
        hold_reg <= live_val;
      end
      if (turn_off && th_en_reg) begin
        hold_act_reg <= 1'b1;
      end else if (turn_on || !th_en_reg || !sel_is_ch || sel_wr_i) begin
        hold_act_reg <= 1'b0;
      end
    end
  end

  // ****************************************
  // ready line
  // ****************************************
  csoc_state_type state_reg;
  csoc_state_type state_next;
  logic [3:0] settle_reg;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      SNS_IDLE: begin
        if (settle_go) begin
          state_next = SNS_SETTLE;
        end
      end
      SNS_SETTLE: begin
        if (turn_off || !oe_next || sel_wr_i) begin
          state_next = SNS_IDLE;
        end else if (settle_reg == SETTLE_CYCLES) begin
          state_next = SNS_VALID;
        end
      end
      SNS_VALID: begin
        if (turn_off || !oe_next || sel_wr_i) begin
          state_next = SNS_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= SNS_IDLE;
      settle_reg <= 4'h0;
    end else begin
      state_reg <= state_next;
      settle_reg <= (state_reg == SNS_SETTLE) ? settle_reg + 4'h1 : 4'h0;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // open drain ready: driven low only while valid, released otherwise
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sense_output_o <= '0;
      sense_output_oe_o <= 1'b0;
      sense_ready_oe_o <= 1'b0;
      sense_select_o <= SEL_RESET;
    end else begin
      sense_output_o <= oe_next ? out_next : '0;
      sense_output_oe_o <= oe_next;
      sense_ready_oe_o <= (state_next == SNS_VALID);
      sense_select_o <= sel_reg;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sense_ready_o <= 1'b0;
    end else begin
      sense_ready_o <= 1'b0;
    end
  end
endmodule // csoc_top

/* File: dv/csoc_properties.sv */
// checker: port-level properties of the sense output block
`timescale 1ns/100ps
module csoc_properties
  import csoc_pkg::*;
#(
  parameter int WIDTH = SENSE_WIDTH
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic sel_wr_i,
  input wire logic sense_select_low_bit_i,
  input wire logic sense_select_high_bit_i,
  input wire logic [1:0] ch_on_i,
  input wire logic [1:0] oc_window_i,
  input wire logic fail_safe_i,
  input wire logic vdd_ok_i,
  input wire logic [WIDTH-1:0] sense_output_o,
  input wire logic sense_output_oe_o,
  input wire logic sense_ready_oe_o,
  input wire logic [1:0] sense_select_o
);
  // ****
  // assertions
  // ****
  sel_copy_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) sel_wr_i
    |-> ##2 sense_select_o == $past({sense_select_high_bit_i, sense_select_low_bit_i}, 2))
    else $error("select copy wrong");
  off_tri_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    sense_select_o == SEL_OFF |-> !sense_output_oe_o) else $error("pin driven when off");
  off_zero_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    !sense_output_oe_o |-> sense_output_o == '0) else $error("value while undriven");
  oc_blank_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (oc_window_i != 2'h0) [*6] |-> !sense_output_oe_o) else $error("no overcurrent blank");
  fs_blank_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (fail_safe_i || !vdd_ok_i) [*6] |-> !sense_output_oe_o) else $error("no fail-safe blank");
  // async clear, so the reset itself cannot be the disable here
  rst_clear_a: assert property (@(posedge clk_sys_i) !rst_n_i
    |-> sense_select_o == SEL_RESET && !sense_output_oe_o) else $error("reset not cleared");
  rdy_off_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (ch_on_i == 2'h0) [*6] |-> !sense_ready_oe_o) else $error("ready with channels off");
endmodule // csoc_properties

/* File: dv/csoc_mcu_model.sv */
// partner: controller input with sense pull-down and ready pull-up
`timescale 1ns/100ps
module csoc_mcu_model (
  input wire logic [11:0] level_i,
  input wire logic oe_i,
  input wire logic rdy_i,
  input wire logic rdy_oe_i,
  output logic [11:0] pin_o,
  output logic rdy_n_o
);
  assign pin_o = oe_i ? level_i : 12'h0;
  assign rdy_n_o = rdy_oe_i ? rdy_i : 1'b1;
endmodule // csoc_mcu_model

/* File: dv/current_sense_output_control_tb.sv */
// testbench: directed scenarios for the sense output block
`timescale 1ns/100ps
module current_sense_output_control_tb;
  import csoc_pkg::*;
  logic clk_sys_i = 0, rst_n_i = 1, sel_wr_i = 0, track_hold_wr_i = 0, track_hold_en_i = 0;
  logic sense_select_low_bit_i = 0, sense_select_high_bit_i = 0, fail_safe_i = 0, vdd_ok_i = 1;
  logic [1:0] ch_on_i = 2'h3, oc_window_i = 2'h0, sense_select_o;
  logic [11:0] ch0_current_i = 12'h123, ch1_current_i = 12'h456, temp_i = 12'h789;
  logic [11:0] sense_output_o, pin;
  logic sense_output_oe_o, sense_ready_o, sense_ready_oe_o, rdy_n;
  int bad_count = 0, comparisons = 0, cyc = 0;
  csoc_top csoc_top_inst (.clk_sys_i, .rst_n_i, .sel_wr_i, .sense_select_low_bit_i,
    .sense_select_high_bit_i, .track_hold_wr_i, .track_hold_en_i, .ch_on_i, .oc_window_i,
    .fail_safe_i, .vdd_ok_i, .ch0_current_i, .ch1_current_i, .temp_i, .sense_output_o,
    .sense_output_oe_o, .sense_ready_o, .sense_ready_oe_o, .sense_select_o);
  csoc_mcu_model csoc_mcu_model_inst (.level_i(sense_output_o), .oe_i(sense_output_oe_o),
    .rdy_i(sense_ready_o), .rdy_oe_i(sense_ready_oe_o), .pin_o(pin), .rdy_n_o(rdy_n));
  // ****
  // helpers
  // ****
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #2;
  endtask
  task automatic chk(input string nm, input logic [11:0] exp, input logic [11:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // strobe stays up between back-to-back writes
  task automatic wsel(input logic [1:0] s, input bit last);
    sel_wr_i = 1;
    {sense_select_high_bit_i, sense_select_low_bit_i} = s;
    tick(1);
    if (last) sel_wr_i = 0;
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_sel;
    logic [11:0] v[4];
    v = '{12'h0, 12'h123, 12'h456, 12'h789};
    wsel(SEL_CH1, 0);
    wsel(SEL_TEMP, 1);
    tick(6);
    chk("back to back", 12'(SEL_TEMP), 12'(sense_select_o));
    for (int s = 0; s < 4; s++) begin
      wsel(2'(s), 1);
      tick(6);
      chk("select", 12'(s), 12'(sense_select_o));
      chk("drive", 12'(s != 0), 12'(sense_output_oe_o));
      chk("pin", v[s], pin);
    end
    $display("done select");
  endtask
  task automatic t_blank;
    wsel(SEL_CH1, 1);
    for (int k = 0; k < 3; k++) begin
      oc_window_i = (k == 0) ? 2'h2 : 2'h0;
      fail_safe_i = (k == 1);
      vdd_ok_i = (k != 2);
      tick(6);
      chk("blank pin", 12'h0, pin);
    end
    vdd_ok_i = 1;
    tick(6);
    chk("unblank pin", 12'h456, pin);
    $display("done blanking");
  endtask
  task automatic t_hold;
    ch_on_i = 2'h0;
    track_hold_wr_i = 1;
    track_hold_en_i = 1;
    wsel(SEL_CH0, 1);
    track_hold_wr_i = 0;
    tick(6);
    chk("ready idle", 12'h1, 12'(rdy_n));
    ch_on_i = 2'h1;
    tick(16);
    chk("ready low", 12'h0, 12'(rdy_n));
    chk("live pin", 12'h123, pin);
    ch_on_i = 2'h0;
    ch0_current_i = 12'h0f0;
    tick(6);
    chk("held pin", 12'h123, pin);
    chk("ready off", 12'h1, 12'(rdy_n));
    ch_on_i = 2'h3;
    $display("done hold");
  endtask
  task automatic t_reset;
    rst_n_i = 0;
    tick(RESET_LOW_CYCLES);
    chk("reset select", 12'(SEL_RESET), 12'(sense_select_o));
    chk("reset pin", 12'h0, pin);
    rst_n_i = 1;
    tick(1);
    chk("reset drive", 12'h0, 12'(sense_output_oe_o));
    $display("done reset");
  endtask
  initial forever #10 clk_sys_i = ~clk_sys_i;
  // hang guard, about five times the cycles the run needs
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      stop_test();
    end
  end
  initial begin
    #2 rst_n_i = 0;
    tick(16);
    rst_n_i = 1;
    t_sel();
    t_blank();
    t_hold();
    t_reset();
    stop_test();
  end
endmodule // current_sense_output_control_tb
bind csoc_top csoc_properties #(.WIDTH(WIDTH)) csoc_properties_inst (.clk_sys_i, .rst_n_i,
  .sel_wr_i, .sense_select_low_bit_i, .sense_select_high_bit_i, .ch_on_i, .oc_window_i,
  .fail_safe_i, .vdd_ok_i, .sense_output_o, .sense_output_oe_o, .sense_ready_oe_o,
  .sense_select_o);
